// File: core/drb_controller.sv
// controller end: link clock divider, command legality, write drive and read capture
`timescale 1ns/1ns
module drb_controller (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronous reset, low
  drb_link_if.ctl link, // pins to the device
  input wire logic req_valid, // request present
  output logic req_ready, // request taken this cycle
  input wire drb_pkg::drb_cmd_type req_cmd, // command
  input wire logic [drb_pkg::BANK_W-1:0] req_bank, // bank
  input wire logic [drb_pkg::ADDR_W-1:0] req_addr, // row, column or mode bits
  input wire logic [drb_pkg::DQ_W-1:0] wr_data, // write beat
  output logic wr_take, // pulse: wr_data consumed
  output logic [drb_pkg::DQ_W-1:0] rd_data, // read beat
  output logic rd_valid, // pulse: rd_data new
  output logic req_error // pulse: request refused by bank state
);
  import drb_pkg::*;
  // ==========================================
  // link clock divider; commands and write data change on falls
  logic [3:0] div;
  logic ck;
  wire step = div == DIV_LAST;
  wire fall_ev = step && ck;
  wire rise_ev = step && !ck;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div <= 4'h0;
      ck <= 1'b0;
    end else begin
      div <= step ? 4'h0 : div + 4'h1;
      if (step)
        ck <= !ck;
    end
  end
  assign link.ck = ck;
  // ==========================================
  // read data synchroniser
  logic [DQ_W-1:0] dq_s1, dq_s2;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
    end
  end
  // ==========================================
  // model of the device bank state
  logic [BANKS-1:0] bank_open, bank_busy;
  logic [3:0] pre_timer [BANKS];
  logic [3:0] ccd;
  logic [1:0] burst_field;
  logic active, is_wr, auto_pre;
  logic [CNT_W-1:0] cnt, lat, beats;
  logic [BANK_W-1:0] bur_bank;
  drb_cmd_type cmd_q;
  logic [BANK_W-1:0] ba_q;
  logic [ADDR_W-1:0] addr_q;
  wire reg_pre = rise_ev && cmd_q == DRB_PRE;
  wire reg_act = rise_ev && cmd_q == DRB_ACT;
  wire reg_rw = rise_ev && (cmd_q == DRB_READ || cmd_q == DRB_WRITE);
  wire [CNT_W-1:0] cnt_next = cnt + 5'h01;
  wire burst_end = rise_ev && active && cnt_next == lat + beats;
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      wire hit = ba_q == BANK_W'(b);
      wire close_now = (reg_pre && (hit || addr_q[AUTO_PRE_BIT])) ||
                       (burst_end && auto_pre && bur_bank == BANK_W'(b));
      assign bank_busy[b] = pre_timer[b] != 4'h0;
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          bank_open[b] <= 1'b0;
          pre_timer[b] <= 4'h0;
        end else if (close_now) begin
          bank_open[b] <= 1'b0;
          pre_timer[b] <= PRE_CK;
        end else if (reg_act && hit) begin
          bank_open[b] <= 1'b1;
        end else if (rise_ev && bank_busy[b]) begin
          pre_timer[b] <= pre_timer[b] - 4'h1;
        end
      end
    end
  endgenerate
  // ==========================================
  // request legality
  wire want_act = req_cmd == DRB_ACT;
  wire want_rw = req_cmd == DRB_READ || req_cmd == DRB_WRITE;
  wire want_mode = req_cmd == DRB_MODE;
  wire sel_open = bank_open[req_bank];
  wire state_bad = (want_act && sel_open) || (want_rw && !sel_open);
  wire act_ok = want_act && !bank_busy[req_bank];
  // one burst at a time keeps a new column command off the running transfer
  wire rw_ok = want_rw && ccd == 4'h0 && !active;
  wire mode_ok = want_mode && !active && bank_open == '0;
  wire other_ok = req_cmd == DRB_PRE || req_cmd == DRB_NOP;
  assign req_ready = fall_ev && (state_bad || act_ok || rw_ok || mode_ok || other_ok);
  wire take = req_valid && req_ready;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_q <= DRB_NOP;
      ba_q <= '0;
      addr_q <= '0;
      req_error <= 1'b0;
      burst_field <= BURST_FIELD_RESET;
    end else begin
      req_error <= take && state_bad;
      if (take && !state_bad) begin
        cmd_q <= req_cmd;
        ba_q <= req_bank;
        addr_q <= req_addr;
        if (want_mode)
          burst_field <= req_addr[1:0];
      end else if (fall_ev) begin
        cmd_q <= DRB_NOP;
      end
    end
  end
  assign link.cmd = cmd_q;
  assign link.ba = ba_q;
  assign link.addr = addr_q;
  // ==========================================
  // burst tracking, counted in link clock rises from the command
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active <= 1'b0;
      is_wr <= 1'b0;
      auto_pre <= 1'b0;
      cnt <= '0;
      lat <= '0;
      beats <= BEATS_EIGHT;
      bur_bank <= '0;
      ccd <= 4'h0;
    end else if (reg_rw) begin
      active <= 1'b1;
      is_wr <= cmd_q == DRB_WRITE;
      auto_pre <= addr_q[AUTO_PRE_BIT];
      cnt <= '0;
      lat <= (cmd_q == DRB_WRITE) ? WRITE_LAT : READ_LAT;
      beats <= drb_beats(burst_field, addr_q[BURST_SEL_BIT]);
      bur_bank <= ba_q;
      ccd <= COLUMN_TO_COLUMN_DELAY;
    end else if (rise_ev) begin
      if (ccd != 4'h0)
        ccd <= ccd - 4'h1;
      if (active)
        cnt <= cnt_next;
      if (burst_end)
        active <= 1'b0;
    end
  end
  // ==========================================
  // data beats sit mid-period so the device's sampled copy is stable
  wire [CNT_W-1:0] beat = cnt - lat;
  wire in_beat = active && cnt >= lat && beat < beats;
  assign wr_take = fall_ev && in_beat && is_wr;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.dq_ctl <= '0;
      link.dq_ctl_oe_n <= 1'b1;
      link.dqs_ctl <= 1'b0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= fall_ev && in_beat && !is_wr;
      if (fall_ev && in_beat && !is_wr)
        rd_data <= dq_s2;
      if (wr_take) begin
        link.dq_ctl <= wr_data;
        link.dq_ctl_oe_n <= 1'b0;
        link.dqs_ctl <= 1'b1;
      end else if (fall_ev) begin
        link.dq_ctl_oe_n <= 1'b1;
        link.dqs_ctl <= 1'b0;
      end
    end
  end
endmodule : drb_controller

// File: core/drb_device.sv
// dram device end: bank state, precharge timing, burst length and data bursts
`timescale 1ns/1ns
module drb_device (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronous reset, low
  drb_link_if.dev link, // pins from the controller
  output logic [drb_pkg::BANKS-1:0] bank_open, // per-bank row open
  output logic cmd_error // pulse: illegal command seen
);
  import drb_pkg::*;
  // ==========================================
  // pin synchronisers
  logic ck_s1, ck_s2, ck_s3;
  logic [2:0] cmd_s1, cmd_s2;
  logic [BANK_W-1:0] ba_s1, ba_s2;
  logic [ADDR_W-1:0] addr_s1, addr_s2;
  logic [DQ_W-1:0] dq_s1, dq_s2;
  logic dqs_s1, dqs_s2;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {ck_s1, ck_s2, ck_s3, dqs_s1, dqs_s2} <= 5'h00;
      {cmd_s1, cmd_s2, ba_s1, ba_s2} <= 12'h000;
      {addr_s1, addr_s2} <= 26'h0000000;
      {dq_s1, dq_s2} <= 32'h00000000;
    end else begin
      {ck_s1, ck_s2, ck_s3} <= {link.ck, ck_s1, ck_s2};
      {cmd_s1, cmd_s2} <= {link.cmd, cmd_s1};
      {ba_s1, ba_s2} <= {link.ba, ba_s1};
      {addr_s1, addr_s2} <= {link.addr, addr_s1};
      {dq_s1, dq_s2} <= {link.dq, dq_s1};
      {dqs_s1, dqs_s2} <= {link.dqs, dqs_s1};
    end
  end
  // ==========================================
  // command decode on each link clock rise
  wire rise = ck_s2 && !ck_s3;
  wire is_act = rise && cmd_s2 == DRB_ACT;
  wire is_pre = rise && cmd_s2 == DRB_PRE;
  wire is_mode = rise && cmd_s2 == DRB_MODE;
  wire is_rw = rise && (cmd_s2 == DRB_READ || cmd_s2 == DRB_WRITE);
  wire pre_all = addr_s2[AUTO_PRE_BIT];
  logic [BANKS-1:0] bank_busy;
  logic [1:0] burst_field;
  logic active, is_wr, auto_pre;
  logic [CNT_W-1:0] cnt, lat, beats;
  logic [BANK_W-1:0] bur_bank;
  logic [COL_W-1:0] bur_col;
  wire [CNT_W-1:0] cnt_next = cnt + 5'h01;
  wire burst_end = rise && active && cnt_next == lat + beats;
  wire rw_ok = is_rw && bank_open[ba_s2] && !active;
  wire act_bad = is_act && (bank_open[ba_s2] || bank_busy[ba_s2]);
  wire rw_bad = is_rw && !rw_ok;
  // ==========================================
  // per-bank row state
  logic [ADDR_W-1:0] open_row [BANKS];
  logic [3:0] pre_timer [BANKS];
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      wire hit = ba_s2 == BANK_W'(b);
      wire close_now = (is_pre && (hit || pre_all)) || (burst_end && auto_pre && bur_bank == BANK_W'(b));
      assign bank_busy[b] = pre_timer[b] != 4'h0;
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          bank_open[b] <= 1'b0;
          pre_timer[b] <= 4'h0;
          open_row[b] <= '0;
        end else if (close_now) begin
          bank_open[b] <= 1'b0;
          pre_timer[b] <= PRE_CK;
        end else if (is_act && hit && !bank_open[b] && !bank_busy[b]) begin
          bank_open[b] <= 1'b1;
          open_row[b] <= addr_s2;
        end else if (rise && bank_busy[b]) begin
          pre_timer[b] <= pre_timer[b] - 4'h1;
        end
      end
    end
  endgenerate
  // ==========================================
  // mode register and burst engine
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      burst_field <= BURST_FIELD_RESET;
      cmd_error <= 1'b0;
    end else begin
      if (is_mode)
        burst_field <= addr_s2[1:0];
      cmd_error <= act_bad || rw_bad;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active <= 1'b0;
      is_wr <= 1'b0;
      auto_pre <= 1'b0;
      cnt <= '0;
      lat <= '0;
      beats <= BEATS_EIGHT;
      bur_bank <= '0;
      bur_col <= '0;
    end else if (rw_ok) begin
      active <= 1'b1;
      is_wr <= cmd_s2 == DRB_WRITE;
      auto_pre <= addr_s2[AUTO_PRE_BIT];
      cnt <= '0;
      lat <= (cmd_s2 == DRB_WRITE) ? WRITE_LAT : READ_LAT;
      beats <= drb_beats(burst_field, addr_s2[BURST_SEL_BIT]);
      bur_bank <= ba_s2;
      bur_col <= addr_s2[COL_W-1:0];
    end else if (rise && active) begin
      cnt <= cnt_next;
      if (burst_end)
        active <= 1'b0;
    end
  end
  // ==========================================
  // data path; the burst ends by link clock count, never by strobe, so bad strobes cannot hang it
  logic [DQ_W-1:0] mem [MEM_DEPTH];
  wire [CNT_W-1:0] rd_beat = cnt_next - lat;
  wire [CNT_W-1:0] wr_beat = cnt_next - lat - 5'h01;
  wire rd_now = rise && active && !is_wr && cnt_next >= lat && rd_beat < beats;
  wire wr_now = rise && active && is_wr && cnt_next > lat && wr_beat < beats;
  wire [BANK_W+COL_W-1:0] rd_idx = {bur_bank, COL_W'(bur_col + rd_beat[COL_W-1:0])};
  wire [BANK_W+COL_W-1:0] wr_idx = {bur_bank, COL_W'(bur_col + wr_beat[COL_W-1:0])};
  always_ff @(posedge mclk) begin
    if (wr_now && dqs_s2)
      mem[wr_idx] <= dq_s2;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.dq_dev <= '0;
      link.dq_dev_oe_n <= 1'b1;
      link.dqs_dev <= 1'b0;
    end else if (rd_now) begin
      link.dq_dev <= mem[rd_idx];
      link.dq_dev_oe_n <= 1'b0;
      link.dqs_dev <= 1'b1;
    end else if (rise) begin
      link.dq_dev_oe_n <= 1'b1;
      link.dqs_dev <= 1'b0;
    end
  end
endmodule : drb_device

// File: dv/ddr3_bank_row_burst_control_test.sv
// bench: controller and device back to back, plus a device fed faulty strobes
`timescale 1ns/1ns
module ddr3_bank_row_burst_control_test;
  import drb_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  drb_cmd_type req_cmd = DRB_NOP;
  logic [BANK_W-1:0] req_bank = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DQ_W-1:0] wr_data = '0;
  logic req_ready, wr_take, rd_valid, req_error;
  logic [DQ_W-1:0] rd_data, seen;
  logic [BANKS-1:0] bank_open;
  logic [BANKS-1:0] bank_open2;
  logic cmd_err, cmd_err2;
  logic err_seen = 1'b0;
  logic err2_seen = 1'b0;
  logic [BANKS-1:0] open_m = '0;
  logic [1:0] field_m = BURST_FIELD_RESET;
  logic [DQ_W-1:0] mem_m [MEM_DEPTH];
  logic [DQ_W-1:0] got2 [8];
  logic [31:0] lfsr = 32'ha8bf;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  drb_link_if link ();
  drb_link_if link2 ();
  drb_controller drb_controller_i (.mclk, .rst_n, .link(link), .req_valid, .req_ready, .req_cmd, .req_bank,
    .req_addr, .wr_data, .wr_take, .rd_data, .rd_valid, .req_error);
  drb_device drb_device_i (.mclk, .rst_n, .link(link), .bank_open, .cmd_error(cmd_err));
  drb_device drb_device_i2 (.mclk, .rst_n, .link(link2), .bank_open(bank_open2), .cmd_error(cmd_err2));
  drb_props drb_props_i (.mclk, .rst_n, .ck(link.ck), .cmd(link.cmd), .ba(link.ba), .addr(link.addr),
    .dq_ctl_oe_n(link.dq_ctl_oe_n), .dqs_ctl(link.dqs_ctl), .dq_dev_oe_n(link.dq_dev_oe_n));
  always #5 mclk = ~mclk;
  // error pulses last one cycle; keep them until the end checks
  always @(posedge mclk) begin
    if (cmd_err === 1'b1) err_seen <= 1'b1;
    if (cmd_err2 === 1'b1) err2_seen <= 1'b1;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end
  // ==========
  // helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic int nbeats(input logic s);
    return (field_m == BURST_FIXED_EIGHT || (field_m == BURST_ON_THE_FLY && s)) ? 8 : 4;
  endfunction : nbeats
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk_data(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_flag(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag
  // the device updates bank state within a link clock plus its sync delay
  task automatic req(input drb_cmd_type c, input logic [2:0] b, input logic [12:0] a);
    logic e;
    e = c == DRB_ACT ? open_m[b] : ((c == DRB_READ || c == DRB_WRITE) && !open_m[b]);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    @(posedge mclk);
    chk_flag({7'h00, req_error}, {7'h00, e});
    if (c == DRB_ACT) open_m[b] = 1'b1;
    if (c == DRB_PRE) open_m = a[AUTO_PRE_BIT] ? 8'h00 : open_m & ~(8'h01 << b);
    if (c == DRB_MODE) field_m = a[1:0];
    if (c == DRB_ACT || c == DRB_PRE) begin
      repeat (16) @(posedge mclk);
      chk_flag(bank_open, open_m);
    end
  endtask : req
  task automatic rw(input drb_cmd_type c, input logic [2:0] b, input logic [2:0] col, input logic ap, input logic s);
    int n;
    n = open_m[b] ? nbeats(s) : 0;
    req(c, b, {s, 1'b0, ap, 7'h00, col});
    for (int i = 0; i < n; i++) begin
      if (c == DRB_WRITE) begin
        while (wr_take !== 1'b1) @(posedge mclk);
        mem_m[{b, 3'(col + i)}] = wr_data;
        wr_data <= 16'(rnd());
      end else begin
        while (rd_valid !== 1'b1) @(posedge mclk);
        chk_data(rd_data, mem_m[{b, 3'(col + i)}]);
      end
      @(posedge mclk);
    end
    if (ap) open_m[b] = 1'b0;
  endtask : rw
  // one link clock period on the faulty-strobe link; samples read data at the fall
  task automatic tick(input drb_cmd_type c, input logic [15:0] d, input logic s, input logic oe_n);
    seen = link2.dq;
    link2.ck <= 1'b0;
    link2.cmd <= c;
    link2.addr <= 13'h1000;
    link2.dq_ctl <= d;
    link2.dqs_ctl <= s;
    link2.dq_ctl_oe_n <= oe_n;
    repeat (8) @(posedge mclk);
    link2.ck <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : tick
  task automatic burst2(input drb_cmd_type c, input logic [7:0] salt, input int bad);
    for (int k = 0; k < 15; k++) begin
      tick(k == 0 ? c : DRB_NOP, {salt, 8'(k - 6)}, k - 6 != bad, !(c == DRB_WRITE && k >= 6 && k < 14));
      if (k >= 6 && k < 14) got2[k - 6] = seen;
    end
  endtask : burst2
  // ==========
  // main sequence
  initial begin
    link2.ck = 1'b0;
    link2.cmd = DRB_NOP;
    link2.ba = '0;
    link2.dq_ctl_oe_n = 1'b1;
    wr_data = 16'(rnd());
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    req(DRB_PRE, 3'h3, 13'h0000);
    req(DRB_MODE, 3'h0, 13'h0001);
    for (int b = 0; b < BANKS; b++) req(DRB_ACT, 3'(b), 13'(rnd()));
    req(DRB_ACT, 3'h2, 13'h0011);
    for (int b = 0; b < BANKS; b++) rw(DRB_WRITE, 3'(b), 3'h0, 1'b0, 1'b1);
    repeat (12) rw(rnd() & 1 ? DRB_READ : DRB_WRITE, 3'(rnd()), 3'(rnd()), 1'b0, 1'(rnd()));
    rw(DRB_WRITE, 3'h5, 3'h2, 1'b1, 1'b0);
    rw(DRB_READ, 3'h5, 3'h2, 1'b0, 1'b1);
    req(DRB_ACT, 3'h5, 13'h0100);
    rw(DRB_READ, 3'h5, 3'h2, 1'b1, 1'b1);
    req(DRB_PRE, 3'h0, 13'h0400);
    req(DRB_PRE, 3'h1, 13'h0400);
    for (int f = 0; f < 4; f++) begin
      req(DRB_MODE, 3'h0, 13'(f));
      req(DRB_ACT, 3'h1, 13'(rnd()));
      rw(DRB_WRITE, 3'h1, 3'h5, 1'b0, 1'(f));
      rw(DRB_READ, 3'h1, 3'h5, 1'b1, 1'(f));
    end
    tick(DRB_ACT, 16'h0000, 1'b0, 1'b1);
    burst2(DRB_WRITE, 8'ha1, 8);
    burst2(DRB_WRITE, 8'hb2, 3);
    burst2(DRB_READ, 8'h00, 8);
    for (int i = 0; i < 8; i++) chk_data(got2[i], {i == 3 ? 8'ha1 : 8'hb2, 8'(i)});
    chk_flag({7'h00, err2_seen}, 8'h00);
    tick(DRB_ACT, 16'h0000, 1'b0, 1'b1);
    // park the link clock low so no false rise follows the reset below
    link2.ck <= 1'b0;
    link2.cmd <= DRB_NOP;
    chk_flag(bank_open2, 8'h01);
    chk_flag({7'h00, err2_seen}, 8'h01);
    // full reset driven by the bench; the controller has no timing-fault reinitialization of its own
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    open_m = '0;
    field_m = BURST_FIELD_RESET;
    @(posedge mclk);
    chk_flag(bank_open2, 8'h00);
    req(DRB_ACT, 3'h4, 13'h0123);
    rw(DRB_WRITE, 3'h4, 3'h1, 1'b0, 1'b0);
    rw(DRB_READ, 3'h4, 3'h1, 1'b0, 1'b0);
    req(DRB_PRE, 3'h4, 13'h0000);
    chk_flag({7'h00, err_seen}, 8'h00);
    wrap_up();
  end
endmodule : ddr3_bank_row_burst_control_test

// File: dv/drb_props.sv
// link checker: command timing, write burst lengths, read latency and bank order
`timescale 1ns/1ns
module drb_props (
  input wire logic mclk, // system clock
  input wire logic rst_n, // reset, low
  input wire logic ck, // link clock
  input wire logic [2:0] cmd, // command code
  input wire logic [drb_pkg::BANK_W-1:0] ba, // bank
  input wire logic [drb_pkg::ADDR_W-1:0] addr, // address
  input wire logic dq_ctl_oe_n, // write drive, low
  input wire logic dqs_ctl, // write strobe
  input wire logic dq_dev_oe_n // read drive, low
);
  import drb_pkg::*;
  localparam int RL_LO = 78;
  localparam int RL_HI = 92;
  logic ck_q;
  logic [1:0] field;
  logic [BANKS-1:0] open_mask;
  logic [7:0] gap;
  logic [7:0] low_cnt;
  logic [7:0] wr_len;
  wire ck_rise = ck && !ck_q;
  wire col_cmd = ck_rise && (cmd == DRB_READ || cmd == DRB_WRITE);
  wire eight = field == BURST_FIXED_EIGHT || (field == BURST_ON_THE_FLY && addr[BURST_SEL_BIT]);
  wire [BANKS-1:0] sel = 8'h01 << ba;
  wire pre_all = ck_rise && cmd == DRB_PRE && addr[AUTO_PRE_BIT];
  wire close_one = (ck_rise && cmd == DRB_PRE) || (col_cmd && addr[AUTO_PRE_BIT]);
  // auto precharge is cleared at the command: lenient, never a false alarm
  wire [BANKS-1:0] next_open = (ck_rise && cmd == DRB_ACT) ? open_mask | sel :
    pre_all ? 8'h00 : close_one ? open_mask & ~sel : open_mask;
  always_ff @(posedge mclk) begin
    ck_q <= rst_n && ck;
    open_mask <= rst_n ? next_open : 8'h00;
    gap <= !rst_n ? 8'hff : col_cmd ? 8'h00 : gap + 8'(gap != 8'hff);
    low_cnt <= dq_ctl_oe_n ? 8'h00 : low_cnt + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) field <= BURST_FIELD_RESET;
    else if (ck_rise && cmd == DRB_MODE) field <= addr[1:0];
    if (col_cmd && cmd == DRB_WRITE) wr_len <= eight ? 8'h80 : 8'h40;
  end
  // ==========
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence rd_start;
    ck_rise && cmd == DRB_READ;
  endsequence
  sequence wr_end;
    $rose(dq_ctl_oe_n);
  endsequence
  AST_CMD_AT_FALL: assert property ($changed({cmd, ba, addr}) |-> $fell(ck))
    else $error("command moved off a clock fall");
  AST_READ_LAT: assert property (rd_start |-> ##[RL_LO:RL_HI] $fell(dq_dev_oe_n))
    else $error("read data late or early");
  AST_WRITE_LEN: assert property (wr_end |-> low_cnt == wr_len)
    else $error("write burst length wrong");
  AST_CCD_GAP: assert property (col_cmd |-> gap >= 8'h3f)
    else $error("column commands too close");
  AST_NO_ACT_OPEN: assert property (ck_rise && cmd == DRB_ACT |-> !open_mask[ba])
    else $error("activate to open bank");
  AST_NO_RW_IDLE: assert property (col_cmd |-> open_mask[ba])
    else $error("column command to idle bank");
  AST_ONE_DRIVER: assert property (dq_ctl_oe_n || dq_dev_oe_n)
    else $error("both ends drive data");
  AST_STROBE_START: assert property ($fell(dq_ctl_oe_n) |-> dqs_ctl)
    else $error("write beat without strobe");
endmodule : drb_props

// File: pkg/drb_link_if.sv
// command, address and data pins between controller and dram device
`timescale 1ns/1ns
interface drb_link_if;
  import drb_pkg::*;
  logic ck;
  logic [2:0] cmd;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_ctl;
  logic dq_ctl_oe_n;
  logic dqs_ctl;
  logic [DQ_W-1:0] dq_dev;
  logic dq_dev_oe_n;
  logic dqs_dev;
  wire [DQ_W-1:0] dq;
  wire dqs;
  // undriven bus reads as zero
  assign dq = !dq_ctl_oe_n ? dq_ctl : (!dq_dev_oe_n ? dq_dev : '0);
  assign dqs = !dq_ctl_oe_n ? dqs_ctl : (!dq_dev_oe_n ? dqs_dev : 1'b0);
  modport ctl (output ck, cmd, ba, addr, dq_ctl, dq_ctl_oe_n, dqs_ctl, input dq, dqs);
  modport dev (input ck, cmd, ba, addr, dq, dqs, output dq_dev, dq_dev_oe_n, dqs_dev);
endinterface : drb_link_if

// File: pkg/drb_pkg.sv
// constants, command codes and burst helpers shared by both ends of the dram link
// ==========================================
// Operation
// - ACTIVE opens bank-selected row
// - row stays open until bank precharged
// - precharge one or all; wait period
// - auto-precharge overlap must not break transfer
// - precharged bank idle until activated again
// - precharge of idle bank is accepted
// - latest precharge restarts precharge period
// - select bit low chops four, high eight
// - burst select bit never column address
// - burst selection works with auto precharge
// - field 00 or 01 plus high gives eight
// - data setup/hold fault corrupts addressed location only
// - strobe faults corrupt location only, no hang
// - controller reinitializes after other timing faults (no such logic here; the bench drives rst_n)
package drb_pkg;
  // ==========================================
  // link geometry
  localparam int BANK_W = 3;
  localparam int BANKS = 8;
  localparam int ADDR_W = 13;
  localparam int DQ_W = 16;
  localparam int CNT_W = 5;
  localparam int BURST_SEL_BIT = 12;
  localparam int AUTO_PRE_BIT = 10;
  localparam int MEM_DEPTH = 64;
  localparam int COL_W = 3;
  // ==========================================
  // timing; the controller's divider makes the link clock
  localparam int MCLK_PS = 10000;
  localparam int CK_HALF = 8;
  localparam int CK_PS = 2 * CK_HALF * MCLK_PS;
  localparam int PRECHARGE_PERIOD_PS = 13750;
  localparam int PRE_CK_INT = (PRECHARGE_PERIOD_PS + CK_PS - 1) / CK_PS;
  localparam logic [3:0] PRE_CK = 4'(PRE_CK_INT < 1 ? 1 : PRE_CK_INT);
  localparam logic [3:0] COLUMN_TO_COLUMN_DELAY = 4'h4;
  localparam logic [CNT_W-1:0] ADDITIVE_LAT = 5'h00;
  localparam logic [CNT_W-1:0] CAS_LAT = 5'h05;
  localparam logic [CNT_W-1:0] CAS_WRITE_LAT = 5'h05;
  localparam logic [CNT_W-1:0] READ_LAT = ADDITIVE_LAT + CAS_LAT;
  localparam logic [CNT_W-1:0] WRITE_LAT = ADDITIVE_LAT + CAS_WRITE_LAT;
  localparam logic [CNT_W-1:0] BEATS_FOUR = 5'h04;
  localparam logic [CNT_W-1:0] BEATS_EIGHT = 5'h08;
  localparam logic [3:0] DIV_LAST = 4'(CK_HALF - 1);
  // ==========================================
  // mode register zero burst field
  localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BURST_FIXED_FOUR = 2'h2;
  localparam logic [1:0] BURST_FIELD_RESET = 2'h0;

  typedef enum logic [2:0] {
    DRB_NOP, DRB_ACT, DRB_PRE, DRB_READ, DRB_WRITE, DRB_MODE
  } drb_cmd_type;

  // eight beats for the fixed-eight field or on-the-fly with select high; four for any other field or select
  function automatic logic [CNT_W-1:0] drb_beats(input logic [1:0] field, input logic sel);
    logic eight;
    eight = (field == BURST_FIXED_EIGHT) || (field == BURST_ON_THE_FLY && sel);
    return eight ? BEATS_EIGHT : BEATS_FOUR;
  endfunction : drb_beats
endpackage : drb_pkg
